// ===== rtl/pcm_cfg.svh
`ifndef PCM_CFG_SVH
`define PCM_CFG_SVH

// timing, tick of one millisecond at 250 MHz
`define PCM_CLK_KHZ        250000
`define PCM_TICK_MS        1
`define PCM_TICK_CYC       (`PCM_TICK_MS * `PCM_CLK_KHZ)
`define PCM_PULSE_SHORT_MS 16'd100
`define PCM_PULSE_LONG_MS  16'd350
`define PCM_START_MAX_S    30
`define PCM_START_MAX_MS   (`PCM_START_MAX_S * 1000)

// register byte offsets
`define PCM_REG_CTRL       8'h00
`define PCM_REG_MUTE       8'h04
`define PCM_REG_MON        8'h08
`define PCM_REG_CLKCNT     8'h0C
`define PCM_REG_STATUS     8'h10

// control field positions
`define PCM_CTRL_LOCK_LSB  0
`define PCM_CTRL_TOPONLY   2
`define PCM_CTRL_PERMIT    3
`define PCM_CTRL_ERRACT    4
`define PCM_CTRL_STLONG    5
`define PCM_CTRL_CKLONG    6

// reset values
`define PCM_CTRL_RST       7'h12
`define PCM_MUTE_RST       16'h0000
`define PCM_MON_RST        16'h1388
`define PCM_CLKCNT_RST     4'h1

`endif

// ===== rtl/pcm_pkg.sv
package pcm_pkg;

	typedef enum logic [1:0] {
		ST_START = 2'b00,
		ST_WAIT  = 2'b01,
		ST_RUN   = 2'b10,
		ST_STOP  = 2'b11
	} pcm_state_t;

	typedef enum logic [1:0] {
		LK_OFF    = 2'b00,
		LK_NONE   = 2'b01,
		LK_ALWAYS = 2'b10,
		LK_DOWN   = 2'b11
	} pcm_lock_t;

endpackage : pcm_pkg

// ===== rtl/pcm_sync.sv
`timescale 1ns/100ps
`default_nettype none
module pcm_sync #(
	parameter int W = 7
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] async_in,
	output var  logic [W-1:0] sync_out
);

	logic [W-1:0] s1_ff;
	logic [W-1:0] s2_ff;
	logic [W-1:0] s3_ff;

	// three stages; a change counts once stages two and three agree
	genvar i;
	generate
		for (i = 0; i < W; i = i + 1) begin : g_bit
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					s1_ff[i]    <= 1'b0;
					s2_ff[i]    <= 1'b0;
					s3_ff[i]    <= 1'b0;
					sync_out[i] <= 1'b0;
				end else begin
					s1_ff[i] <= async_in[i];
					s2_ff[i] <= s1_ff[i];
					s3_ff[i] <= s2_ff[i];
					if (s2_ff[i] == s3_ff[i]) begin
						sync_out[i] <= s3_ff[i];
					end
				end
			end
		end
	endgenerate

endmodule : pcm_sync
`default_nettype wire

// ===== rtl/pcm_top.sv
// The register addresses and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "pcm_cfg.svh"
module pcm_top #(
	parameter int TICK_CYC = `PCM_TICK_CYC
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output var  logic [31:0] hrdata,
	output var  logic        hreadyout,
	output var  logic        hresp,
	input  wire logic        main_en,
	input  wire logic        start_permit,
	input  wire logic        curtain,
	input  wire logic        upper_reversal_point,
	input  wire logic        ramp_up,
	input  wire logic        start_btn,
	input  wire logic        drive_en,
	output var  logic        press_en,
	output var  logic        start_req,
	output var  logic        clk_req,
	output var  logic        seq_timeout,
	output var  logic        unauth_int,
	output var  logic        no_restart,
	output var  logic        err_flag
);

	logic [6:0]           pins_s;
	logic                 men_s;
	logic                 perm_s;
	logic                 cur_s;
	logic                 top_s;
	logic                 ramp_s;
	logic                 stb_s;
	logic                 drv_s;
	logic                 cur_d_ff;
	logic                 top_d_ff;
	logic                 stb_d_ff;
	logic [31:0]          tick_cnt_ff;
	logic                 tick;
	logic [6:0]           ctrl_ff;
	logic [15:0]          mute_ff;
	logic [15:0]          mon_ff;
	logic [3:0]           clkcnt_ff;
	logic                 ph_wr_ff;
	logic                 ph_act_ff;
	logic [7:0]           ph_addr_ff;
	logic [31:0]          nxt_rdata;
	pcm_pkg::pcm_state_t  state_ff;
	pcm_pkg::pcm_state_t  nxt_state;
	pcm_pkg::pcm_lock_t   lock;
	logic [15:0]          st_hi_ff;
	logic [15:0]          ck_lo_ff;
	logic [15:0]          mute_cnt_ff;
	logic [15:0]          mon_cnt_ff;
	logic [3:0]           left_ff;
	logic                 full_ff;
	logic                 need_start_ff;
	logic                 mute_hit_ff;
	logic                 top_seen_ff;
	logic [15:0]          st_min;
	logic [15:0]          ck_min;
	logic                 start_ok;
	logic                 clock_ok;
	logic                 cur_fall;
	logic                 cur_rise;
	logic                 top_rise;
	logic                 muted;
	logic                 intervene;
	logic                 mon_over;
	logic                 set_unauth;
	logic                 set_tout;

	pcm_sync #(
		.W (7)
	) u_sync (
		.clk      (clk),
		.rst      (rst),
		.async_in ({drive_en, start_btn, ramp_up, upper_reversal_point,
		            curtain, start_permit, main_en}),
		.sync_out (pins_s)
	);

	assign men_s  = pins_s[0];
	assign perm_s = pins_s[1];
	assign cur_s  = pins_s[2];
	assign top_s  = pins_s[3];
	assign ramp_s = pins_s[4];
	assign stb_s  = pins_s[5];
	assign drv_s  = pins_s[6];
	assign lock   = pcm_pkg::pcm_lock_t'(ctrl_ff[`PCM_CTRL_LOCK_LSB +: 2]);

	// edge history of the cleaned pins
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cur_d_ff <= 1'b0;
			top_d_ff <= 1'b0;
			stb_d_ff <= 1'b0;
		end else begin
			cur_d_ff <= cur_s;
			top_d_ff <= top_s;
			stb_d_ff <= stb_s;
		end
	end

	assign cur_fall = cur_d_ff & ~cur_s;
	assign cur_rise = ~cur_d_ff & cur_s;
	assign top_rise = ~top_d_ff & top_s;

	// millisecond tick; all pulse and window times count in ticks
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tick_cnt_ff <= 32'h00000000;
		end else if (tick) begin
			tick_cnt_ff <= 32'h00000000;
		end else begin
			tick_cnt_ff <= tick_cnt_ff + 32'h00000001;
		end
	end

	assign tick = (tick_cnt_ff == 32'(TICK_CYC - 1));

	// ahb-lite address phase capture, zero wait states
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ph_act_ff  <= 1'b0;
			ph_wr_ff   <= 1'b0;
			ph_addr_ff <= 8'h00;
		end else if (hready) begin
			ph_act_ff  <= hsel & htrans[1];
			ph_wr_ff   <= hsel & htrans[1] & hwrite;
			ph_addr_ff <= haddr[7:0];
		end
	end

	// register writes land in the data phase
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl_ff   <= `PCM_CTRL_RST;
			mute_ff   <= `PCM_MUTE_RST;
			mon_ff    <= `PCM_MON_RST;
			clkcnt_ff <= `PCM_CLKCNT_RST;
		end else if (ph_wr_ff) begin
			case (ph_addr_ff)
				`PCM_REG_CTRL:   ctrl_ff   <= hwdata[6:0];
				`PCM_REG_MUTE:   mute_ff   <= hwdata[15:0];
				`PCM_REG_MON:    mon_ff    <= hwdata[15:0];
				`PCM_REG_CLKCNT: clkcnt_ff <= hwdata[3:0];
				default: ;
			endcase
		end
	end

	// read mux in the address phase so data is ready next edge
	always_comb begin
		nxt_rdata = 32'h00000000;
		case (haddr[7:0])
			`PCM_REG_CTRL:   nxt_rdata = {25'h0000000, ctrl_ff};
			`PCM_REG_MUTE:   nxt_rdata = {16'h0000, mute_ff};
			`PCM_REG_MON:    nxt_rdata = {16'h0000, mon_ff};
			`PCM_REG_CLKCNT: nxt_rdata = {28'h0000000, clkcnt_ff};
			`PCM_REG_STATUS: nxt_rdata = {18'h00000, left_ff, state_ff,
			                  press_en, start_req, clk_req, seq_timeout,
			                  unauth_int, no_restart, err_flag, 1'b0};
			default:         nxt_rdata = 32'h00000000;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hrdata    <= 32'h00000000;
			hreadyout <= 1'b0;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			if (hready && hsel && htrans[1] && !hwrite) begin
				hrdata <= nxt_rdata;
			end
		end
	end

	assign st_min = ctrl_ff[`PCM_CTRL_STLONG] ? `PCM_PULSE_LONG_MS
	                                          : `PCM_PULSE_SHORT_MS;
	assign ck_min = ctrl_ff[`PCM_CTRL_CKLONG] ? `PCM_PULSE_LONG_MS
	                                          : `PCM_PULSE_SHORT_MS;

	// start pulse high time; counter saturates past the 30 s ceiling
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_hi_ff <= 16'h0000;
		end else if (!stb_s) begin
			st_hi_ff <= 16'h0000;
		end else if (tick && st_hi_ff <= 16'(`PCM_START_MAX_MS)) begin
			st_hi_ff <= st_hi_ff + 16'h0001;
		end
	end

	// the first tick counted can come at once, so only one fewer whole ms is sure, hence strict >
	assign start_ok = stb_d_ff & ~stb_s & (st_hi_ff > st_min)
	                & (st_hi_ff <= 16'(`PCM_START_MAX_MS));

	// curtain low time, a short dip does not count toward the interventions owed
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ck_lo_ff <= 16'h0000;
		end else if (cur_s) begin
			ck_lo_ff <= 16'h0000;
		end else if (tick && ck_lo_ff != 16'hFFFF) begin
			ck_lo_ff <= ck_lo_ff + 16'h0001;
		end
	end

	assign clock_ok = cur_rise & (ck_lo_ff > ck_min);

	// ramp-up muting window, restarts whenever ramp-up drops
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mute_cnt_ff <= 16'h0000;
		end else if (!ramp_s || state_ff != pcm_pkg::ST_RUN) begin
			mute_cnt_ff <= 16'h0000;
		end else if (tick && mute_cnt_ff < mute_ff) begin
			mute_cnt_ff <= mute_cnt_ff + 16'h0001;
		end
	end

	assign muted = (mute_ff != 16'h0000) & ramp_s & ~top_s
	             & (mute_cnt_ff < mute_ff);
	assign intervene = cur_fall & ~muted;

	// sequence watchdog over the waiting phase
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mon_cnt_ff <= 16'h0000;
		end else if (state_ff != pcm_pkg::ST_WAIT) begin
			mon_cnt_ff <= 16'h0000;
		end else if (tick && mon_cnt_ff != 16'hFFFF) begin
			mon_cnt_ff <= mon_cnt_ff + 16'h0001;
		end
	end

	assign mon_over = (mon_ff != 16'h0000) & (mon_cnt_ff >= mon_ff);

	// flag causes, evaluated against the current state
	always_comb begin
		set_tout   = (state_ff == pcm_pkg::ST_WAIT) & mon_over;
		set_unauth = 1'b0;
		if (state_ff == pcm_pkg::ST_RUN) begin
			if (top_rise && mute_hit_ff && lock == pcm_pkg::LK_ALWAYS) begin
				set_unauth = 1'b1;
			end else if (intervene && lock != pcm_pkg::LK_NONE
			             && lock != pcm_pkg::LK_OFF) begin
				set_unauth = 1'b1;
			end
		end
	end

	// main sequencer
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			pcm_pkg::ST_START: begin
				if (start_ok && men_s) begin
					nxt_state = pcm_pkg::ST_WAIT;
				end
			end
			pcm_pkg::ST_WAIT: begin
				if (set_tout) begin
					nxt_state = pcm_pkg::ST_START;
				end else if (!men_s) begin
					nxt_state = pcm_pkg::ST_STOP;
				end else if (left_ff == 4'h0 && !seq_timeout
				             && !unauth_int
				             && (!full_ff || !ctrl_ff[`PCM_CTRL_PERMIT]
				                 || perm_s)) begin
					nxt_state = pcm_pkg::ST_RUN;
				end
			end
			pcm_pkg::ST_RUN: begin
				if (!men_s || intervene) begin
					nxt_state = pcm_pkg::ST_STOP;
				end else if (set_unauth) begin
					nxt_state = pcm_pkg::ST_START;
				end else if (top_rise) begin
					nxt_state = pcm_pkg::ST_WAIT;
				end
			end
			pcm_pkg::ST_STOP: begin
				if (top_seen_ff && men_s && cur_s
				    && (!ctrl_ff[`PCM_CTRL_TOPONLY] || !drv_s)) begin
					nxt_state = need_start_ff ? pcm_pkg::ST_START
					                          : pcm_pkg::ST_WAIT;
				end
			end
			default: nxt_state = pcm_pkg::ST_START;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_ff <= pcm_pkg::ST_START;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// interventions still owed before the stroke may run
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			left_ff <= 4'h0;
		end else if (nxt_state == pcm_pkg::ST_WAIT
		             && state_ff != pcm_pkg::ST_WAIT) begin
			left_ff <= clkcnt_ff;
		end else if (state_ff == pcm_pkg::ST_WAIT && clock_ok
		             && left_ff != 4'h0) begin
			left_ff <= left_ff - 4'h1;
		end
	end

	// permit is only looked at after a full start, never while running
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			full_ff <= 1'b0;
		end else if (state_ff == pcm_pkg::ST_START) begin
			full_ff <= 1'b1;
		end else if (state_ff == pcm_pkg::ST_RUN) begin
			full_ff <= 1'b0;
		end
	end

	// a stop out of the run state in interlock-always mode, or one with an unauthorised intervention, must be recovered by a full start
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			need_start_ff <= 1'b0;
		end else if (state_ff == pcm_pkg::ST_RUN && nxt_state ==
		             pcm_pkg::ST_STOP) begin
			need_start_ff <= set_unauth | (lock == pcm_pkg::LK_ALWAYS);
		end else if (state_ff == pcm_pkg::ST_START) begin
			need_start_ff <= 1'b0;
		end
	end

	// remembers a curtain break hidden by muting during this stroke
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mute_hit_ff <= 1'b0;
		end else if (state_ff != pcm_pkg::ST_RUN) begin
			mute_hit_ff <= 1'b0;
		end else if (cur_fall && muted) begin
			mute_hit_ff <= 1'b1;
		end
	end

	// top reached since the stop; top already high counts too
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			top_seen_ff <= 1'b0;
		end else if (state_ff != pcm_pkg::ST_STOP) begin
			top_seen_ff <= 1'b0;
		end else if (top_s) begin
			top_seen_ff <= 1'b1;
		end
	end

	// sticky faults; set wins over the acknowledge in the same cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			seq_timeout <= 1'b0;
		end else if (set_tout) begin
			seq_timeout <= 1'b1;
		end else if (state_ff == pcm_pkg::ST_START && start_ok) begin
			seq_timeout <= 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			unauth_int <= 1'b0;
		end else if (set_unauth) begin
			unauth_int <= 1'b1;
		end else if ((state_ff == pcm_pkg::ST_START && start_ok)
		             || (cur_rise && lock != pcm_pkg::LK_ALWAYS
		                 && state_ff != pcm_pkg::ST_START)) begin
			unauth_int <= 1'b0;
		end
	end

	// registered outputs from next state and this cycle's fault causes, so all move together
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			press_en   <= 1'b0;
			start_req  <= 1'b1;
			clk_req    <= 1'b0;
			no_restart <= 1'b0;
			err_flag   <= 1'b0;
		end else begin
			press_en   <= (nxt_state == pcm_pkg::ST_RUN) & men_s
			            & ~set_unauth & ~set_tout;
			start_req  <= (nxt_state == pcm_pkg::ST_START);
			clk_req    <= (nxt_state == pcm_pkg::ST_WAIT);
			no_restart <= (nxt_state == pcm_pkg::ST_STOP);
			err_flag   <= ctrl_ff[`PCM_CTRL_ERRACT]
			            & (seq_timeout | unauth_int | set_tout
			               | set_unauth);
		end
	end

endmodule : pcm_top
`default_nettype wire

// ===== tb/pcm_top_properties.sv
`timescale 1ns/100ps
`default_nettype none
module pcm_props (
	input wire logic clk,
	input wire logic rst,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic main_en,
	input wire logic press_en,
	input wire logic start_req,
	input wire logic clk_req,
	input wire logic seq_timeout,
	input wire logic unauth_int,
	input wire logic no_restart,
	input wire logic err_flag
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// main enable gone long enough to pass the input cleaner
	sequence s_main_gone;
		!main_en [*7];
	endsequence
	sequence s_fault;
		seq_timeout || unauth_int;
	endsequence
	chk_main_off: assert property (s_main_gone |-> !press_en)
		else $error("press enable high with main enable low");
	chk_req_excl: assert property (start_req |-> !press_en)
		else $error("start request and press enable both high");
	chk_start_hold: assert property (
		$rose(press_en) |-> !$past(start_req) && !start_req)
		else $error("press enable rose while start was awaited");
	chk_start_clr: assert property ($fell(start_req) |-> clk_req)
		else $error("no intervention awaited after start");
	chk_fault_off: assert property (s_fault |=> !press_en)
		else $error("press enable high during a fault");
	chk_err_sum: assert property (
		err_flag |-> s_fault or $past(seq_timeout) || $past(unauth_int))
		else $error("error flag without a fault");
	chk_stop_flag: assert property (
		$fell(press_en) && !main_en && !unauth_int && !seq_timeout
		|-> ##[0:2] no_restart)
		else $error("stop by main enable not flagged");
	chk_norst_hold: assert property (no_restart |-> !press_en)
		else $error("press enable high while restart blocked");
	// ready is low through reset, so skip the first edge after release
	chk_bus_okay: assert property (!$past(rst) |-> hreadyout && !hresp)
		else $error("bus slave stalled or answered error");
endmodule : pcm_props
bind pcm_top pcm_props u_props (.clk(clk), .rst(rst), .hreadyout(hreadyout),
	.hresp(hresp), .main_en(main_en), .press_en(press_en),
	.start_req(start_req), .clk_req(clk_req), .seq_timeout(seq_timeout),
	.unauth_int(unauth_int), .no_restart(no_restart), .err_flag(err_flag));
`default_nettype wire

// ===== tb/pcm_press_model.sv
`timescale 1ns/100ps
`default_nettype none
module pcm_press_model #(
	parameter int STROKE = 2000,
	parameter int TOP    = 200,
	parameter int RAMP   = 100
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        press_en,
	input  wire logic        jog,
	input  wire logic        brk_go,
	input  wire logic [15:0] brk_cyc,
	output var  logic        curtain,
	output var  logic        upper_reversal_point,
	output var  logic        ramp_up,
	output var  logic        drive_en
);
	logic [15:0] brk_ff;
	logic [15:0] pos_ff;
	logic        drv_ff;
	// intervention length counted down, curtain low meanwhile
	always_ff @(posedge clk or posedge rst) begin
		if (rst) brk_ff <= 16'h0000;
		else if (brk_go) brk_ff <= brk_cyc;
		else if (brk_ff != 16'h0000) brk_ff <= brk_ff - 16'h0001;
	end
	assign curtain = (brk_ff == 16'h0000);
	// drive lags enable a cycle, like a contactor would
	always_ff @(posedge clk or posedge rst) begin
		if (rst) drv_ff <= 1'b0;
		else drv_ff <= press_en;
	end
	assign drive_en = drv_ff;
	// crank moves when driven or jogged in a setup mode
	always_ff @(posedge clk or posedge rst) begin
		if (rst) pos_ff <= 16'h0000;
		else if (drv_ff || jog)
			pos_ff <= (pos_ff == 16'(STROKE - 1)) ? 16'h0000 : pos_ff + 16'h0001;
	end
	assign upper_reversal_point = (pos_ff >= 16'(STROKE - TOP));
	assign ramp_up = (drv_ff || jog) && (pos_ff < 16'(RAMP));
endmodule : pcm_press_model
`default_nettype wire

// ===== tb/tb_press_clock_mode_control.sv
`timescale 1ns/100ps
`default_nettype none
`include "pcm_cfg.svh"
module tb_press_clock_mode_control;
	localparam int TK = 4;
	logic clk, rst, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic main_en, start_permit, curtain, upper_reversal_point, ramp_up;
	logic start_btn, drive_en, press_en, start_req, clk_req, seq_timeout;
	logic unauth_int, no_restart, err_flag, jog, brk_go;
	logic [15:0] brk_cyc;
	int failures, n_tests;
	pcm_top #(.TICK_CYC(TK)) u_dut (.clk, .rst, .hsel, .haddr, .htrans,
		.hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
		.hresp, .main_en, .start_permit, .curtain, .upper_reversal_point,
		.ramp_up, .start_btn, .drive_en, .press_en, .start_req, .clk_req,
		.seq_timeout, .unauth_int, .no_restart, .err_flag);
	pcm_press_model u_press (.clk, .rst, .press_en, .jog, .brk_go, .brk_cyc,
		.curtain, .upper_reversal_point, .ramp_up, .drive_en);
	// free running 250 MHz clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task test_done;
		$display("checks %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : test_done
	// settle past the edge so registered outputs have landed
	task chk(input logic [31:0] g, input logic [31:0] e);
		#1;
		n_tests++;
		if (g !== e) begin
			$display("ERROR %0t got %h exp %h", $time, g, e);
			failures++;
		end
		// back on the edge, so following stimulus lands at a rising edge
		@(posedge clk);
	endtask : chk
	task cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc
	// one single transfer, held until the slave is ready each phase
	task xfer(input logic [31:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask : xfer
	task wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(a, 1'b1, d, q);
	endtask : wr
	task rdchk(input logic [31:0] a, input logic [31:0] e);
		logic [31:0] q;
		xfer(a, 1'b0, 32'h00000000, q);
		chk(q, e);
	endtask : rdchk
	task spulse(input int ms);
		start_btn <= 1'b1;
		cyc(ms * TK);
		start_btn <= 1'b0;
		cyc(20);
	endtask : spulse
	task brk(input int ms);
		brk_cyc <= 16'(ms * TK);
		brk_go <= 1'b1;
		@(posedge clk);
		brk_go <= 1'b0;
		cyc(ms * TK + 30);
	endtask : brk
	task until_top(input logic v);
		for (int i = 0; i < 3000 && upper_reversal_point !== v; i++)
			@(posedge clk);
	endtask : until_top
	// main sequence
	initial begin
		rst = 1'b1; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
		hsize = 3'h2; hwdata = 32'h0; main_en = 1'b1; start_permit = 1'b1;
		start_btn = 1'b0; jog = 1'b0; brk_go = 1'b0; brk_cyc = 16'h0000;
		failures = 0; n_tests = 0;
		cyc(8);
		rst <= 1'b0;
		cyc(2);
		chk(start_req, 32'h1);
		rdchk(`PCM_REG_CTRL, 32'h12);
		rdchk(`PCM_REG_MUTE, 32'h0);
		rdchk(`PCM_REG_MON, 32'h1388);
		rdchk(`PCM_REG_CLKCNT, 32'h1);
		rdchk(32'h20, 32'h0);
		$display("test 1 done");
		wr(`PCM_REG_CTRL, 32'h1A);
		spulse(50);
		chk(start_req, 32'h1);
		spulse(110);
		chk(start_req, 32'h0);
		chk(clk_req, 32'h1);
		brk(50);
		chk(press_en, 32'h0);
		brk(110);
		chk(press_en, 32'h1);
		start_permit <= 1'b0;
		cyc(20);
		chk(press_en, 32'h1);
		$display("test 2 done");
		main_en <= 1'b0;
		cyc(20);
		chk(press_en, 32'h0);
		chk(no_restart, 32'h1);
		main_en <= 1'b1;
		cyc(20);
		chk(press_en, 32'h0);
		jog <= 1'b1;
		until_top(1'b1);
		jog <= 1'b0;
		cyc(20);
		chk(no_restart, 32'h0);
		chk(start_req, 32'h1);
		$display("test 3 done");
		wr(`PCM_REG_MON, 32'h14);
		spulse(110);
		cyc(200);
		chk(seq_timeout, 32'h1);
		chk(err_flag, 32'h1);
		chk(start_req, 32'h1);
		wr(`PCM_REG_MON, 32'h0);
		spulse(110);
		chk(seq_timeout, 32'h0);
		chk(err_flag, 32'h0);
		$display("test 4 done");
		wr(`PCM_REG_CTRL, 32'h11);
		brk(110);
		chk(press_en, 32'h1);
		until_top(1'b0);
		main_en <= 1'b0;
		cyc(20);
		main_en <= 1'b1;
		jog <= 1'b1;
		until_top(1'b1);
		jog <= 1'b0;
		cyc(20);
		chk(clk_req, 32'h1);
		chk(start_req, 32'h0);
		$display("test 5 done");
		// interlock always, muting on: break hidden in ramp-up
		wr(`PCM_REG_CTRL, 32'h12);
		wr(`PCM_REG_MUTE, 32'h32);
		brk(110);
		until_top(1'b0);
		brk(30);
		chk(press_en, 32'h1);
		until_top(1'b1);
		cyc(20);
		chk(unauth_int, 32'h1);
		chk(start_req, 32'h1);
		chk(press_en, 32'h0);
		chk(err_flag, 32'h1);
		spulse(110);
		chk(unauth_int, 32'h0);
		$display("test 6 done");
		// unmuted break near the top, then permit gating a full start
		brk(110);
		brk(30);
		chk(unauth_int, 32'h1);
		chk(start_req, 32'h1);
		spulse(110);
		chk(unauth_int, 32'h0);
		wr(`PCM_REG_CTRL, 32'h1A);
		brk(110);
		chk(press_en, 32'h0);
		start_permit <= 1'b1;
		cyc(20);
		chk(press_en, 32'h1);
		$display("test 7 done");
		test_done();
	end
	// watchdog well past the expected run length
	initial begin
		cyc(60000);
		failures++;
		test_done();
	end
endmodule : tb_press_clock_mode_control
`default_nettype wire
